// file: rtl/pdec_pkg.sv
package pdec_pkg;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int unsigned P2_WIDTH = 8;
  localparam logic [P2_WIDTH-1:0] WAKE_MASK_RST = 8'h00;

  // ****************************************
  // Sequencer states, one-hot
  // ****************************************
  typedef enum logic [3:0] {
    PDEC_RUN   = 4'h1,
    PDEC_CHECK = 4'h2,
    PDEC_QIDLE = 4'h4,
    PDEC_PDOWN = 4'h8
  } pdec_state_t;

  // ****************************************
  // Instruction context from the core
  // ****************************************
  typedef struct packed {
    logic power_down_instruction; // one-cycle pulse
    logic next_ext;               // next code in external memory
    logic mux_bus;                // multiplexed bus in use
    logic tristate_wb;            // memory_tristate_wait_bit
    logic prev_xwrite;            // last instruction wrote outside
  } pdec_instr_t;

  // ****************************************
  // Status towards the core
  // ****************************************
  typedef struct packed {
    logic pdown;     // power-down entered
    logic qidle;     // fetch stalled, quasi-idle
    logic ignored;   // one-cycle pulse: instruction ignored
    logic irq_block; // interrupts and event transfers held off
  } pdec_stat_t;

endpackage

// file: rtl/pdec_power_down_entry_control.sv
`timescale 1ns/1ps
`default_nettype none

module pdec_power_down_entry_control
  import pdec_pkg::*;
#(
  parameter int unsigned P2_W = pdec_pkg::P2_WIDTH
)
(
  // Clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  // Configuration
  input  wire logic                       wake_source_select_in,
  input  wire logic [P2_W-1:0]            wake_enable_in,
  input  wire logic [P2_W-1:0]            wake_active_high_in,
  // Pins
  input  wire logic                       nmi_n_in,
  input  wire logic [P2_W-1:0]            p2_in,
  // Core
  input  wire pdec_pkg::pdec_instr_t      instr_in,
  input  wire logic                       wakeup_in,
  output var  pdec_pkg::pdec_stat_t       stat_out
);
  import pdec_pkg::*;

  // ****************************************
  // Parameter check
  // ****************************************
  // Port 2 holds at most sixteen wake pins
  if (P2_W < 1 || P2_W > 16)
  begin : g_bad_width
    $error("P2_W out of range");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic            nmi_s1_r, nmi_s2_r;
  logic [P2_W-1:0] p2_s1_r, p2_s2_r;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      nmi_s1_r <= 1'b1;
      nmi_s2_r <= 1'b1;
      p2_s1_r  <= '0;
      p2_s2_r  <= '0;
    end
    else
    begin
      nmi_s1_r <= nmi_n_in;
      nmi_s2_r <= nmi_s1_r;
      p2_s1_r  <= p2_in;
      p2_s2_r  <= p2_s1_r;
    end
  end

  // ****************************************
  // Decode
  // ****************************************
  // Pin at active level: xnor with its polarity
  wire [P2_W-1:0] p2_act  = ~(p2_s2_r ^ wake_active_high_in) & wake_enable_in;
  wire            p2_hit  = |p2_act;
  wire            nmi_hi  = nmi_s2_r;
  wire            wake_pending = wake_source_select_in ? p2_hit : nmi_hi;
  // Stall checked ahead of the pins: the fault is not an ignore case
  wire            mux_stall   = instr_in.mux_bus && !instr_in.tristate_wb;
  wire            write_stall = instr_in.prev_xwrite;
  wire            stall_cond  =
    instr_in.next_ext && (mux_stall || write_stall);

  // ****************************************
  // Sequencer
  // ****************************************
  pdec_state_t state_r, state_nxt;
  logic        ign_nxt;

  always_comb
  begin
    state_nxt = state_r;
    ign_nxt   = 1'b0;
    unique case (state_r)
      PDEC_RUN:
        if (instr_in.power_down_instruction)
          state_nxt = PDEC_CHECK;
      PDEC_CHECK:
        if (stall_cond)
          state_nxt = PDEC_QIDLE;
        else if (wake_pending)
        begin
          state_nxt = PDEC_RUN;
          ign_nxt   = 1'b1;
        end
        else
          state_nxt = PDEC_PDOWN;
      PDEC_QIDLE:
        if (!nmi_s2_r)
          state_nxt = PDEC_PDOWN;
      PDEC_PDOWN:
        if (wakeup_in)
          state_nxt = PDEC_RUN;
      default:
        state_nxt = PDEC_RUN;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_r  <= PDEC_RUN;
      stat_out <= '0;
    end
    else
    begin
      state_r            <= state_nxt;
      stat_out.pdown     <= (state_nxt == PDEC_PDOWN);
      stat_out.qidle     <= (state_nxt == PDEC_QIDLE);
      stat_out.ignored   <= ign_nxt;
      // Watchdog is outside and keeps running; only servicing stops
      stat_out.irq_block <= (state_nxt == PDEC_QIDLE);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // One clock domain, so clock and reset are given once
  default clocking cb_chk @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_clean_check;
    state_r == PDEC_CHECK && !stall_cond;
  endsequence

  sequence s_stall_seen;
    state_r == PDEC_CHECK && stall_cond;
  endsequence

  sequence s_nmi_low_stall;
    state_r == PDEC_QIDLE && !nmi_s2_r;
  endsequence

  a_nmi_ignore: assert property (
    s_clean_check ##0 (!wake_source_select_in && nmi_s2_r)
    |=> stat_out.ignored && state_r == PDEC_RUN)
    else $error("power-down not ignored with nmi high");

  a_p2_ignore: assert property (
    s_clean_check ##0 (wake_source_select_in && (|p2_act))
    |=> stat_out.ignored && !stat_out.pdown)
    else $error("power-down entered with wake pin active");

  a_normal_entry: assert property (
    s_clean_check ##0 !wake_pending
    |=> stat_out.pdown && !stat_out.ignored)
    else $error("power-down not entered");

  a_nmi_low_entry: assert property (
    s_clean_check ##0 (!wake_source_select_in && !nmi_s2_r)
    |=> stat_out.pdown)
    else $error("entry refused with nmi low");

  a_pins_idle_entry: assert property (
    s_clean_check ##0 (wake_source_select_in && !(|p2_act))
    |=> stat_out.pdown)
    else $error("entry refused with wake pins idle");

  a_stall_mux: assert property (
    state_r == PDEC_CHECK && instr_in.next_ext && instr_in.mux_bus
      && !instr_in.tristate_wb |=> stat_out.qidle)
    else $error("mux bus stall missing");

  a_stall_write: assert property (
    state_r == PDEC_CHECK && instr_in.next_ext && instr_in.prev_xwrite
      |=> stat_out.qidle && !stat_out.ignored)
    else $error("write stall missing");

  a_stall_first: assert property (
    s_stall_seen
    |=> stat_out.irq_block && !stat_out.ignored
      && !stat_out.pdown)
    else $error("stall lost to the wake pins");

  a_qidle_block: assert property (
    state_r == PDEC_QIDLE |-> stat_out.irq_block && !stat_out.pdown)
    else $error("interrupts not held in quasi-idle");

  a_nmi_release: assert property (
    s_nmi_low_stall
    |=> stat_out.pdown && !stat_out.qidle)
    else $error("nmi did not complete entry");

  a_qidle_holds: assert property (
    state_r == PDEC_QIDLE && nmi_s2_r
    |=> (state_r == PDEC_QIDLE) && $stable(stat_out.qidle))
    else $error("quasi-idle left without nmi");

  // Requests outside run are dropped silently
  a_refused_busy: assert property (
    instr_in.power_down_instruction && state_r != PDEC_RUN
    |=> state_r != PDEC_CHECK)
    else $error("request taken outside run");

  a_wake_exit: assert property (
    state_r == PDEC_PDOWN && wakeup_in
    |=> !stat_out.pdown && state_r == PDEC_RUN)
    else $error("power-down not left on wakeup");

endmodule // pdec_power_down_entry_control

`default_nettype wire

// file: sim/pdec_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module pdec_pins_model
#(
  parameter int unsigned W   = 8,
  parameter int unsigned DLY = 1
)
(
  // Requested levels
  input  wire logic [W-1:0] p2_req_in,
  input  wire logic         nmi_req_in,
  // Pins
  output logic      [W-1:0] p2_out,
  output logic              nmi_n_out
);
  // Pins move inside the low phase, clear of the sampling edge
  assign #DLY p2_out    = p2_req_in;
  assign #DLY nmi_n_out = nmi_req_in;
endmodule // pdec_pins_model
`default_nettype wire

// file: sim/pdec_power_down_entry_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pdec_power_down_entry_control_tb_top;
  import pdec_pkg::*;
  // ********
  // Stimulus
  // ********
  logic        clk_in = 1'b0, rst_n_in = 1'b0, sel = 1'b0;
  logic        nmi_req = 1'b1, wakeup = 1'b0, nmi_n;
  logic [7:0]  en = 8'h00, hi = 8'h00, p2_req = 8'h00, p2;
  pdec_instr_t ins = '0;
  pdec_stat_t  st, x;
  int          errors = 0, tests_run = 0, cyc = 0, i;
  integer      seed = 32'h3e6a;
  always #2 clk_in = ~clk_in;
  pdec_pins_model #(.W(8), .DLY(1)) i_pdec_pins_model (.p2_req_in(p2_req),
    .nmi_req_in(nmi_req), .p2_out(p2), .nmi_n_out(nmi_n));
  pdec_power_down_entry_control #(.P2_W(8)) i_pdec_power_down_entry_control (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .wake_source_select_in(sel),
    .wake_enable_in(en), .wake_active_high_in(hi), .nmi_n_in(nmi_n),
    .p2_in(p2), .instr_in(ins), .wakeup_in(wakeup), .stat_out(st));
  task automatic check(input pdec_stat_t got, exp, input string nm);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic pdec_stat_t expect_of(input pdec_instr_t t);
    pdec_stat_t r;
    r = '0;
    if (t.next_ext && ((t.mux_bus && !t.tristate_wb) || t.prev_xwrite))
      {r.qidle, r.irq_block} = 2'b11;
    else if (sel ? |(en & ~(p2_req ^ hi)) : nmi_req)
      r.ignored = 1'b1;
    else
      r.pdown = 1'b1;
    return r;
  endfunction
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      errors++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (10) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    check(st, '0, "reset");
    for (i = 0; i < 40; i++)
    begin
      sel = (i < 2) ? 1'b0 : 1'($random(seed));
      en = 8'($random(seed));
      hi = 8'($random(seed));
      p2_req = (i < 4) ? ~hi : 8'($random(seed));
      nmi_req = (i < 2) ? 1'(i) : 1'($random(seed));
      // Unsafe code placement drawn on purpose
      ins = (i == 2) ? 5'h0c : (i == 3) ? 5'h09 : 5'($random(seed)) & 5'h0f;
      x = expect_of(ins);
      if (x.qidle)
        nmi_req = 1'b1;
      repeat (3) @(negedge clk_in);
      ins.power_down_instruction = 1'b1;
      @(negedge clk_in);
      ins.power_down_instruction = 1'b0;
      @(negedge clk_in);
      if (x.qidle)
        check(st, x, "stall");
      else
        check(st, x, "decision");
      if (x.qidle)
      begin
        nmi_req = 1'b0;
        // A request while stalled must be dropped
        ins.power_down_instruction = 1'b1;
        @(negedge clk_in);
        ins.power_down_instruction = 1'b0;
        @(negedge clk_in);
        check(st, x, "stall held");
        x = 4'h8;
        @(negedge clk_in);
        check(st, x, "stall exit");
      end
      if (x.pdown)
      begin
        wakeup = 1'b1;
        @(negedge clk_in);
        wakeup = 1'b0;
      end
      else
        @(negedge clk_in);
      check(st, '0, "back to run");
    end
    // Reset while stalled, then a request on the first edge after it
    sel = 1'b0;
    nmi_req = 1'b1;
    ins = 5'h0c;
    repeat (3) @(negedge clk_in);
    ins.power_down_instruction = 1'b1;
    @(negedge clk_in);
    ins.power_down_instruction = 1'b0;
    @(negedge clk_in);
    check(st, 4'h5, "stall again");
    rst_n_in = 1'b0;
    ins = '0;
    repeat (2) @(negedge clk_in);
    check(st, '0, "mid reset");
    rst_n_in = 1'b1;
    ins.power_down_instruction = 1'b1;
    @(negedge clk_in);
    ins.power_down_instruction = 1'b0;
    @(negedge clk_in);
    check(st, 4'h2, "first after reset");
    print_verdict();
  end
endmodule // pdec_power_down_entry_control_tb_top
`default_nettype wire
